// >>> rtl/core_ops_pkg.sv
package core_ops_pkg;

    // instruction encodings (negate and product upper bits compared under a mask, discard as a whole word)
    localparam logic [15:0] negate_pattern   = 16'h6c00;
    localparam logic [15:0] negate_mask      = 16'hfe00;
    localparam logic [15:0] product_pattern  = 16'h0200;
    localparam logic [15:0] product_mask     = 16'hfe00;
    localparam logic [15:0] discard_code     = 16'h0006;
    localparam logic [15:0] nop_code         = 16'h0000;
    localparam logic [3:0]  nop_alt_nibble   = 4'hf;

    // operand field positions
    localparam int bank_mode_bit = 8;
    localparam int file_msb      = 7;

    // indexed literal offset window upper bound
    localparam logic [7:0] indexed_limit = 8'h5f;
    // access bank upper part starts here (lower part, 0x00 to 0x5f, is file bank 0)
    localparam logic [7:0] access_split  = 8'h60;
    localparam logic [3:0] access_high_bank = 4'hf;

    // status bit positions
    localparam int carry_pos = 0;
    localparam int half_pos  = 1;
    localparam int null_pos  = 2;
    localparam int wrap_pos  = 3;
    localparam int msb_pos   = 4;

    localparam logic [4:0] status_reset  = 5'h00;
    localparam logic [7:0] product_reset = 8'h00;

    // quarter-cycle phases of one instruction cycle
    typedef enum logic [1:0] {
        phase_decode  = 2'b00,
        phase_read    = 2'b01,
        phase_process = 2'b10,
        phase_write   = 2'b11
    } phase_type;

    typedef enum logic [1:0] {
        op_none    = 2'b00,
        op_negate  = 2'b01,
        op_product = 2'b10,
        op_discard = 2'b11
    } op_type;

endpackage : core_ops_pkg

// >>> rtl/addr_former.sv
`timescale 1ns/1ps
module addr_former
    import core_ops_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        load,
    input  wire logic        bank_mode,
    input  wire logic [7:0]  file_field,
    input  wire logic        extended_en,
    input  wire logic [3:0]  bank_pointer,
    input  wire logic [11:0] index_base,
    output logic      [11:0] data_addr
);
    import core_ops_pkg::*;

    logic [11:0] next_addr;

    always_comb begin
        if (bank_mode) begin
            next_addr = {bank_pointer, file_field};
        end else if (extended_en && file_field <= indexed_limit) begin
            next_addr = 12'(index_base + {4'h0, file_field});
        end else if (file_field < access_split) begin
            next_addr = {4'h0, file_field};
        end else begin
            next_addr = {access_high_bank, file_field};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            data_addr <= 12'h000;
        end else if (load) begin
            data_addr <= next_addr;
        end
    end

endmodule : addr_former

// >>> rtl/negate_multiply_stack_ops.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - negate register, write back same location
// - negate updates five arithmetic status flags
// - bank bit selects access or pointer bank
// - extended set indexes operands up to 95
// - unsigned multiply into product pair, flags kept
module negate_multiply_stack_ops
    import core_ops_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        extended_en,
    input  wire logic [3:0]  bank_pointer,
    input  wire logic [11:0] index_base,
    input  wire logic [7:0]  accumulator,
    input  wire logic [7:0]  mem_rdata,
    output logic      [11:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    output logic      [7:0]  product_upper,
    output logic      [7:0]  product_lower,
    output logic      [4:0]  status_flags,
    output logic             stack_pop,
    output logic      [1:0]  phase,
    output logic             busy
);
    import core_ops_pkg::*;

    phase_type   cur_phase;
    op_type      cur_op;
    logic [7:0]  operand;
    logic [7:0]  result;
    logic [15:0] product;
    logic [8:0]  sum_full;
    logic [4:0]  half_sum;
    logic        is_negate;
    logic        is_product;
    logic        is_discard;
    logic        take;

    assign is_negate  = (instr_word & negate_mask) == negate_pattern;
    assign is_product = (instr_word & product_mask) == product_pattern;
    assign is_discard = instr_word == discard_code;
    // idle cycles accept a new word; anything not decoded (nop included) runs as no operation
    assign take       = (cur_phase == phase_decode) && instr_valid;

    // four quarter phases per instruction, started by a valid word
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cur_phase <= phase_decode;
        end else begin
            unique case (cur_phase)
                phase_decode:  cur_phase <= take ? phase_read : phase_decode;
                phase_read:    cur_phase <= phase_process;
                phase_process: cur_phase <= phase_write;
                phase_write:   cur_phase <= phase_decode;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cur_op <= op_none;
        end else if (take) begin
            if (is_negate) begin
                cur_op <= op_negate;
            end else if (is_product) begin
                cur_op <= op_product;
            end else if (is_discard) begin
                cur_op <= op_discard;
            end else begin
                cur_op <= op_none;
            end
        end
    end

    addr_former u_addr (
        .mclk         (mclk),
        .rstn         (rstn),
        .load         (take),
        .bank_mode    (instr_word[bank_mode_bit]),
        .file_field   (instr_word[file_msb:0]),
        .extended_en  (extended_en),
        .bank_pointer (bank_pointer),
        .index_base   (index_base),
        .data_addr    (mem_addr)
    );

    // memory read strobe during the read quarter for operand instructions
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mem_rd <= 1'b0;
        end else begin
            mem_rd <= take && (is_negate || is_product);
        end
    end

    // read data are taken one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            operand <= 8'h00;
        end else if (cur_phase == phase_process) begin
            operand <= mem_rdata;
        end
    end

    assign sum_full = {1'b0, ~operand} + 9'h001;
    assign half_sum = {1'b0, ~operand[3:0]} + 5'h01;
    assign result   = sum_full[7:0];
    assign product  = {8'h00, operand} * {8'h00, accumulator};

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mem_wr    <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_wr    <= (cur_phase == phase_process) && (cur_op == op_negate);
            mem_wdata <= (cur_phase == phase_process) ? ~mem_rdata + 8'h01 : mem_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            status_flags <= status_reset;
        end else if (cur_phase == phase_write && cur_op == op_negate) begin
            status_flags[carry_pos] <= sum_full[8];
            status_flags[half_pos]  <= half_sum[4];
            status_flags[null_pos]  <= result == 8'h00;
            status_flags[wrap_pos]  <= result == 8'h80;
            status_flags[msb_pos]   <= result[7];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            product_upper <= product_reset;
            product_lower <= product_reset;
        end else if (cur_phase == phase_write && cur_op == op_product) begin
            product_upper <= product[15:8];
            product_lower <= product[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stack_pop <= 1'b0;
        end else begin
            stack_pop <= (cur_phase == phase_read) && (cur_op == op_discard);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            phase <= 2'b00;
            busy  <= 1'b0;
        end else begin
            phase <= take ? 2'b01 : (cur_phase == phase_decode ? 2'b00 : 2'(cur_phase + 2'b01));
            busy  <= take || (cur_phase != phase_decode && cur_phase != phase_write);
        end
    end

    sequence neg_read_s;
        mem_rd && cur_op == op_negate;
    endsequence
    neg_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        neg_read_s |-> ##2 (mem_wr && mem_wdata == 8'(~$past(mem_rdata) + 8'h01)))
        else $error("negate write missing or wrong");

    neg_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        mem_rd |-> ##2 $stable(mem_addr))
        else $error("address moved during instruction");

    flag_null_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cur_phase == phase_write && cur_op == op_negate) |=> status_flags[null_pos] == (mem_wdata == 8'h00))
        else $error("null flag wrong after negate");

    flag_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(cur_phase == phase_write && cur_op == op_negate) |=> $stable(status_flags))
        else $error("flags changed outside negate");

    bank_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && instr_word[bank_mode_bit]) |=> mem_addr == {$past(bank_pointer), $past(instr_word[7:0])})
        else $error("banked address wrong");

    index_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && !instr_word[bank_mode_bit] && extended_en && instr_word[7:0] <= indexed_limit)
        |=> mem_addr == 12'($past(index_base) + {4'h0, $past(instr_word[7:0])}))
        else $error("indexed address wrong");

    prod_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cur_phase == phase_write && cur_op == op_product)
        |=> {product_upper, product_lower} == {8'h00, $past(operand)} * {8'h00, $past(accumulator)} && !mem_wr)
        else $error("product pair wrong");

    prod_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(cur_phase == phase_write && cur_op == op_product) |=> $stable({product_upper, product_lower}))
        else $error("product pair changed outside multiply");

    prod_no_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_product) |=> !mem_wr [*4])
        else $error("multiply wrote data memory");

    rd_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        mem_rd |=> !mem_rd)
        else $error("read strobe longer than one cycle");

    wr_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
        mem_wr |=> !mem_wr)
        else $error("write strobe longer than one cycle");

    wr_only_neg_a: assert property (@(posedge mclk) disable iff (!rstn)
        mem_wr |-> cur_op == op_negate)
        else $error("write strobe from a non-negate");

    sequence neg_take_s;
        take && is_negate;
    endsequence
    sequence read_then_write_s;
        mem_rd ##2 mem_wr;
    endsequence
    neg_steps_a: assert property (@(posedge mclk) disable iff (!rstn)
        neg_take_s |-> ##1 read_then_write_s)
        else $error("negate steps out of order");

    busy_phase_a: assert property (@(posedge mclk) disable iff (!rstn)
        busy == (phase != 2'b00))
        else $error("busy and phase disagree");

    busy_refuse_a: assert property (@(posedge mclk) disable iff (!rstn)
        busy |-> !take)
        else $error("word taken while busy");

    flag_carry_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cur_phase == phase_write && cur_op == op_negate) |=> status_flags[carry_pos] == ($past(operand) == 8'h00))
        else $error("carry flag wrong after negate");

    flag_half_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cur_phase == phase_write && cur_op == op_negate) |=> status_flags[half_pos] == ($past(operand[3:0]) == 4'h0))
        else $error("half carry flag wrong after negate");

    // sign wrap on most negative value
    flag_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cur_phase == phase_write && cur_op == op_negate) |=> status_flags[wrap_pos] == ($past(operand) == 8'h80))
        else $error("sign wrap flag wrong after negate");

    flag_msb_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cur_phase == phase_write && cur_op == op_negate) |=> status_flags[msb_pos] == mem_wdata[7])
        else $error("msb flag wrong after negate");

    access_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && !instr_word[bank_mode_bit] && !(extended_en && instr_word[7:0] <= indexed_limit))
        |=> mem_addr == (($past(instr_word[7:0]) < access_split) ? {4'h0, $past(instr_word[7:0])}
                                                              : {access_high_bank, $past(instr_word[7:0])}))
        else $error("access bank address wrong");

    discard_pop_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_discard) |-> ##2 stack_pop)
        else $error("discard did not pop");

    pop_only_discard_a: assert property (@(posedge mclk) disable iff (!rstn)
        stack_pop |-> cur_op == op_discard)
        else $error("pop from another instruction");

    pop_once_a: assert property (@(posedge mclk) disable iff (!rstn)
        stack_pop |=> !stack_pop [*3])
        else $error("stack pop repeated");

endmodule : negate_multiply_stack_ops

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import core_ops_pkg::*;
    logic        mclk, rstn, instr_valid, extended_en, mem_rd, mem_wr, stack_pop, busy;
    logic [15:0] instr_word;
    logic [3:0]  bank_pointer;
    logic [11:0] index_base, mem_addr;
    logic [7:0]  accumulator, mem_rdata, mem_wdata, product_upper, product_lower;
    logic [4:0]  status_flags, exp_flags;
    logic [1:0]  phase;
    logic [15:0] exp_prod, addr_q[$], wdata_q[$], ops[4];
    logic [20:0] res_q[$], res;
    int          fail_count, compares, pops_due, seed, k;
    event        settled;

    negate_multiply_stack_ops negate_multiply_stack_ops_inst (.mclk(mclk), .rstn(rstn),
        .instr_valid(instr_valid), .instr_word(instr_word), .extended_en(extended_en),
        .bank_pointer(bank_pointer), .index_base(index_base), .accumulator(accumulator),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .product_upper(product_upper), .product_lower(product_lower),
        .status_flags(status_flags), .stack_pop(stack_pop), .phase(phase), .busy(busy));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // poke offers a stack discard while busy; it must be ignored
    task automatic run(input logic [15:0] w, input logic [7:0] rd, input logic ext, input logic [3:0] bp,
                       input logic [11:0] ib, input logic [7:0] acc, input logic poke);
        logic [7:0]  f, r;
        logic [11:0] a;
        f = w[7:0];
        r = 8'h00 - rd;
        if (w[bank_mode_bit]) a = {bp, f};
        else if (ext && f <= indexed_limit) a = ib + {4'h0, f};
        else a = (f < access_split) ? {4'h0, f} : {access_high_bank, f};
        if ((w & negate_mask) == negate_pattern) begin
            addr_q.push_back({4'h0, a});
            wdata_q.push_back({8'h00, r});
            exp_flags = {r[7], r == 8'h80, r == 8'h00, rd[3:0] == 4'h0, rd == 8'h00};
        end else if ((w & product_mask) == product_pattern) begin
            addr_q.push_back({4'h0, a});
            exp_prod = {8'h00, rd} * {8'h00, acc};
        end else if (w == discard_code) pops_due++;
        res_q.push_back({exp_flags, exp_prod});
        @(posedge mclk);
        instr_valid  <= 1'b1;
        instr_word   <= w;
        extended_en  <= ext;
        bank_pointer <= bp;
        index_base   <= ib;
        accumulator  <= acc;
        @(posedge mclk);
        instr_valid <= poke;
        instr_word  <= poke ? discard_code : w;
        @(posedge mclk);
        instr_valid <= 1'b0;
        mem_rdata   <= rd;
        @(posedge mclk);
        mem_rdata <= ~rd;
        @(posedge mclk);
        @(posedge mclk);
        #1 -> settled;
    endtask : run

    always @(posedge mclk) begin
        #1;
        if (mem_rd === 1'b1) check({4'h0, mem_addr}, addr_q.size() ? addr_q.pop_front() : 16'hffff);
        if (mem_rd === 1'b1) check({13'h0, phase, busy}, 16'h0003);
        if (mem_wr === 1'b1) check({8'h00, mem_wdata}, wdata_q.size() ? wdata_q.pop_front() : 16'hffff);
        if (mem_wr === 1'b1) check({13'h0, phase, busy}, 16'h0007);
        if (stack_pop === 1'b1) begin
            check({15'h0, pops_due > 0}, 16'h0001);
            pops_due--;
        end
    end

    always @(settled) begin
        res = res_q.pop_front();
        check({11'h0, status_flags}, {11'h0, res[20:16]});
        check({product_upper, product_lower}, res[15:0]);
        check({13'h0, phase, busy}, 16'h0000);
    end

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        conclude();
    end

    initial begin
        {rstn, instr_valid, extended_en, instr_word, bank_pointer} = '0;
        {index_base, accumulator, mem_rdata} = '0;
        seed = 58;
        exp_flags = status_reset;
        exp_prod = 16'h0000;
        ops = '{negate_pattern, product_pattern, discard_code, nop_code};
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1 check({11'h0, status_flags, product_upper, product_lower}, 16'h0000);
        run(negate_pattern | 16'h0142, 8'h3a, 1'b0, 4'h2, 12'h000, 8'h00, 1'b0);
        run(product_pattern | 16'h0110, 8'hb5, 1'b0, 4'h3, 12'h000, 8'hc4, 1'b0);
        run(negate_pattern | 16'h005f, 8'h00, 1'b1, 4'h0, 12'h100, 8'h11, 1'b1);
        run(negate_pattern | 16'h0060, 8'h80, 1'b1, 4'h7, 12'h100, 8'h11, 1'b0);
        run(product_pattern | 16'h0010, 8'hff, 1'b0, 4'h7, 12'h200, 8'hff, 1'b0);
        run(discard_code, 8'h55, 1'b0, 4'h0, 12'h000, 8'h00, 1'b0);
        run(nop_code, 8'h55, 1'b0, 4'h0, 12'h000, 8'h00, 1'b1);
        run({nop_alt_nibble, 12'h0a5}, 8'h55, 1'b0, 4'h0, 12'h000, 8'h00, 1'b0);
        run(discard_code, 8'h55, 1'b0, 4'h0, 12'h000, 8'h00, 1'b0);
        for (int i = 0; i < 60; i++) begin
            k = {$random(seed)} % 4;
            run(ops[k] | (k < 2 ? 16'($random(seed)) & 16'h01ff : 16'h0000), 8'($random(seed)),
                1'($random(seed)), 4'($random(seed)), 12'($random(seed)), 8'($random(seed)),
                1'($random(seed)));
        end
        check(16'(pops_due), 16'h0000);
        check(16'(addr_q.size() + wdata_q.size()), 16'h0000);
        conclude();
    end
endmodule : tb
